// [src/bbcca_config_reg.sv]
// I2C-reached configuration register for buck-boost channel one
`timescale 1ns/10ps
`default_nettype none

module bbcca_config_reg #(
  parameter bit HIGH_VOLT_VARIANT = 1'b0
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        sclIn,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOeN,
  input  wire logic        otpAddrSel,
  input  wire logic [7:0]  otpDefault,
  input  wire logic        systemResetEvent,
  output logic      [1:0]  ch1PeakCurrentLimit,
  output logic      [5:0]  ch1TargetVoltageCode,
  output logic      [9:0]  peakLimitMa,
  output logic      [22:0] targetVoltUv,
  output logic             targetVoltReserved
);

  bbcca_pkg::bbcca_regs_s st;
  bbcca_pkg::bbcca_regs_s nxt;

  logic        sclRise;
  logic        sclFall;
  logic        startCond;
  logic        stopCond;
  logic [6:0]  myAddr;
  logic [22:0] decVolt;
  logic        decRsvd;

  function automatic logic [9:0] limit_ma(input logic [1:0] code);
    case (code)
      2'b00:   limit_ma = bbcca_pkg::LIMIT_MA_CODE0;
      2'b01:   limit_ma = bbcca_pkg::LIMIT_MA_CODE1;
      2'b10:   limit_ma = bbcca_pkg::LIMIT_MA_CODE2;
      default: limit_ma = bbcca_pkg::LIMIT_MA_CODE3;
    endcase
  endfunction

  // Unmapped pointers read as zero
  function automatic logic [7:0] read_byte(input logic [7:0] p, input logic [7:0] v);
    read_byte = (p == bbcca_pkg::REG_OFFSET) ? v : 8'h00;
  endfunction

  assign sclRise   = sclIn & ~st.sclQ;
  assign sclFall   = ~sclIn & st.sclQ;
  assign startCond = st.sclQ & sclIn & st.sdaQ & ~sdaIn;
  assign stopCond  = st.sclQ & sclIn & ~st.sdaQ & sdaIn;
  assign myAddr    = otpAddrSel ? bbcca_pkg::I2C_ADDR_SEL1 : bbcca_pkg::I2C_ADDR_SEL0;

  // Decodes the next register value so outputs move with the register
  bbcca_volt_decode #(
    .HIGH_VOLT_VARIANT (HIGH_VOLT_VARIANT)
  ) u_decode (
    .code     (nxt.regVal[bbcca_pkg::VCODE_MSB:bbcca_pkg::VCODE_LSB]),
    .voltUv   (decVolt),
    .reserved (decRsvd)
  );

  always_comb
  begin
    nxt      = st;
    nxt.sclQ = sclIn;
    nxt.sdaQ = sdaIn;
    if (rst)
    begin
      nxt.state   = bbcca_pkg::ST_IDLE;
      nxt.shift   = 8'h00;
      nxt.bitCnt  = 4'h0;
      nxt.isRead  = 1'b0;
      nxt.byteCnt = 2'h0;
      nxt.ptr     = 8'h00;
      nxt.regVal  = bbcca_pkg::REG_RESET;
      nxt.sdaOeN  = 1'b1;
    end
    else if (startCond)
    begin
      // Repeated start restarts addressing, pointer is kept
      nxt.state   = bbcca_pkg::ST_RX;
      nxt.bitCnt  = 4'h0;
      nxt.byteCnt = 2'h0;
      nxt.sdaOeN  = 1'b1;
    end
    else if (stopCond)
    begin
      nxt.state  = bbcca_pkg::ST_IDLE;
      nxt.sdaOeN = 1'b1;
    end
    else
    begin
      case (st.state)
        bbcca_pkg::ST_IDLE:
        begin
          nxt.sdaOeN = 1'b1;
        end
        bbcca_pkg::ST_RX:
        begin
          if (sclRise)
          begin
            nxt.shift  = {st.shift[6:0], sdaIn};
            nxt.bitCnt = st.bitCnt + 4'h1;
          end
          else if (sclFall && st.bitCnt == 4'h8)
          begin
            nxt.bitCnt = 4'h0;
            nxt.state  = bbcca_pkg::ST_ACK;
            nxt.sdaOeN = 1'b0;
            if (st.byteCnt == 2'h0)
            begin
              nxt.isRead = st.shift[0];
              if (st.shift[7:1] != myAddr)
              begin
                nxt.state  = bbcca_pkg::ST_IDLE;
                nxt.sdaOeN = 1'b1;
              end
            end
            else if (st.byteCnt == 2'h1)
            begin
              nxt.ptr = st.shift;
            end
            else
            begin
              if (st.ptr == bbcca_pkg::REG_OFFSET)
              begin
                nxt.regVal = st.shift;
              end
              nxt.ptr = st.ptr + 8'h01;
            end
          end
        end
        bbcca_pkg::ST_ACK:
        begin
          if (sclFall)
          begin
            nxt.sdaOeN = 1'b1;
            nxt.state  = bbcca_pkg::ST_RX;
            if (st.byteCnt != 2'h2)
            begin
              nxt.byteCnt = st.byteCnt + 2'h1;
            end
            if (st.byteCnt == 2'h0 && st.isRead)
            begin
              nxt.shift  = read_byte(st.ptr, st.regVal);
              nxt.sdaOeN = nxt.shift[7];
              nxt.state  = bbcca_pkg::ST_TX;
            end
          end
        end
        bbcca_pkg::ST_TX:
        begin
          if (sclFall)
          begin
            if (st.bitCnt == 4'h7)
            begin
              nxt.bitCnt = 4'h0;
              nxt.sdaOeN = 1'b1;
              nxt.state  = bbcca_pkg::ST_MACK;
            end
            else
            begin
              nxt.shift  = {st.shift[6:0], 1'b0};
              nxt.sdaOeN = nxt.shift[7];
              nxt.bitCnt = st.bitCnt + 4'h1;
            end
          end
        end
        bbcca_pkg::ST_MACK:
        begin
          if (sclRise)
          begin
            if (sdaIn)
            begin
              nxt.state = bbcca_pkg::ST_IDLE;
            end
            else
            begin
              nxt.bitCnt = 4'h1;
            end
          end
          else if (sclFall && st.bitCnt == 4'h1)
          begin
            nxt.bitCnt = 4'h0;
            nxt.ptr    = st.ptr + 8'h01;
            nxt.shift  = read_byte(st.ptr + 8'h01, st.regVal);
            nxt.sdaOeN = nxt.shift[7];
            nxt.state  = bbcca_pkg::ST_TX;
          end
        end
        default:
        begin
          nxt.state  = bbcca_pkg::ST_IDLE;
          nxt.sdaOeN = 1'b1;
        end
      endcase
      // reset event beats a host write
      if (systemResetEvent)
      begin
        nxt.regVal = otpDefault;
      end
    end
    nxt.sdaOut   = 1'b0;
    nxt.limitMa  = limit_ma(nxt.regVal[bbcca_pkg::LIMIT_MSB:bbcca_pkg::LIMIT_LSB]);
    nxt.voltUv   = decVolt;
    nxt.voltRsvd = decRsvd;
  end

  // Reset acts even while the clock enable holds the block frozen
  always_ff @(posedge clk_sys)
  begin
    if (rst || ce)
    begin
      st <= nxt;
    end
  end

  assign sdaOut               = st.sdaOut;
  assign sdaOeN               = st.sdaOeN;
  assign ch1PeakCurrentLimit  = st.regVal[bbcca_pkg::LIMIT_MSB:bbcca_pkg::LIMIT_LSB];
  assign ch1TargetVoltageCode = st.regVal[bbcca_pkg::VCODE_MSB:bbcca_pkg::VCODE_LSB];
  assign peakLimitMa          = st.limitMa;
  assign targetVoltUv         = st.voltUv;
  assign targetVoltReserved   = st.voltRsvd;

  sequence s_data_done;
    ce && st.state == bbcca_pkg::ST_RX && sclFall && st.bitCnt == 4'h8 && st.byteCnt == 2'h2;
  endsequence

  sequence s_addr_done;
    ce && st.state == bbcca_pkg::ST_RX && sclFall && st.bitCnt == 4'h8 && st.byteCnt == 2'h0;
  endsequence

  a_limit_decode: assert property (@(posedge clk_sys) disable iff (rst)
    peakLimitMa == (ch1PeakCurrentLimit == 2'b00 ? bbcca_pkg::LIMIT_MA_CODE0 :
    ch1PeakCurrentLimit == 2'b01 ? bbcca_pkg::LIMIT_MA_CODE1 :
    ch1PeakCurrentLimit == 2'b10 ? bbcca_pkg::LIMIT_MA_CODE2 : bbcca_pkg::LIMIT_MA_CODE3))
    else $error("peak limit decode wrong");

  a_volt_low: assert property (@(posedge clk_sys) disable iff (rst)
    !HIGH_VOLT_VARIANT |-> targetVoltUv == bbcca_pkg::VLOW_BASE_UV
    + 23'(ch1TargetVoltageCode) * bbcca_pkg::VLOW_STEP_UV) else $error("low voltage map wrong");

  a_code_order: assert property (@(posedge clk_sys) disable iff (rst)
    !HIGH_VOLT_VARIANT && ch1TargetVoltageCode == 6'h01 |->
    targetVoltUv == bbcca_pkg::VLOW_BASE_UV + bbcca_pkg::VLOW_STEP_UV) else $error("code lsb wrong");

  a_volt_high: assert property (@(posedge clk_sys) disable iff (rst)
    HIGH_VOLT_VARIANT |-> targetVoltUv == bbcca_pkg::VHIGH_BASE_UV + 23'({ch1TargetVoltageCode[1:0],
    ch1TargetVoltageCode[5:2]}) * bbcca_pkg::VHIGH_STEP_UV) else $error("high voltage map wrong");

  a_high_reserved: assert property (@(posedge clk_sys) disable iff (rst)
    targetVoltReserved == (HIGH_VOLT_VARIANT && {ch1TargetVoltageCode[1:0],
    ch1TargetVoltageCode[5:2]} > bbcca_pkg::VHIGH_MAX_IDX)) else $error("reserved flag wrong");

  a_reset_reload: assert property (@(posedge clk_sys) disable iff (rst)
    ce && systemResetEvent |=> {ch1PeakCurrentLimit, ch1TargetVoltageCode} == $past(otpDefault))
    else $error("fused default not reloaded");

  a_write_lands: assert property (@(posedge clk_sys) disable iff (rst)
    s_data_done ##0 (st.ptr == bbcca_pkg::REG_OFFSET && !systemResetEvent) |=>
    st.regVal == $past(st.shift) && peakLimitMa == limit_ma($past(st.shift[7:6])))
    else $error("write not presented next cycle");

  a_foreign_addr: assert property (@(posedge clk_sys) disable iff (rst)
    s_addr_done ##0 (st.shift[7:1] != myAddr && !startCond && !stopCond) |=>
    sdaOeN && st.state == bbcca_pkg::ST_IDLE) else $error("answered a foreign address");

  a_freeze_hold: assert property (@(posedge clk_sys) disable iff (rst)
    !ce && !rst |=> $stable(st)) else $error("state moved while frozen");

endmodule

`default_nettype wire

// [src/bbcca_pkg.sv]
// Constants and types for the buck-boost channel one configuration register
package bbcca_pkg;

  // Register map
  localparam logic [7:0]  REG_OFFSET      = 8'h2B;
  localparam logic [7:0]  REG_RESET       = 8'h00;
  localparam int          LIMIT_MSB       = 7;
  localparam int          LIMIT_LSB       = 6;
  localparam int          VCODE_MSB       = 5;
  localparam int          VCODE_LSB       = 0;

  // Target addresses picked by the address-select fuse
  localparam logic [6:0]  I2C_ADDR_SEL0   = 7'h40;
  localparam logic [6:0]  I2C_ADDR_SEL1   = 7'h48;

  // Peak current limit in mA for codes 00..11
  localparam logic [9:0]  LIMIT_MA_CODE0  = 10'h3E8;
  localparam logic [9:0]  LIMIT_MA_CODE1  = 10'h362;
  localparam logic [9:0]  LIMIT_MA_CODE2  = 10'h2C3;
  localparam logic [9:0]  LIMIT_MA_CODE3  = 10'h1F4;

  // Target voltage transfer functions, in microvolts
  localparam logic [22:0] VLOW_BASE_UV    = 23'h0C_3500;
  localparam logic [22:0] VLOW_STEP_UV    = 23'h00_30D4;
  localparam logic [22:0] VHIGH_BASE_UV   = 23'h24_9F00;
  localparam logic [22:0] VHIGH_STEP_UV   = 23'h00_C350;
  localparam logic [5:0]  VHIGH_MAX_IDX   = 6'h39;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX   = 5'h02,
    ST_ACK  = 5'h04,
    ST_TX   = 5'h08,
    ST_MACK = 5'h10
  } bbcca_state_e;

  typedef struct packed {
    bbcca_state_e state;
    logic         sclQ;
    logic         sdaQ;
    logic [7:0]   shift;
    logic [3:0]   bitCnt;
    logic         isRead;
    logic [1:0]   byteCnt;
    logic [7:0]   ptr;
    logic [7:0]   regVal;
    logic         sdaOut;
    logic         sdaOeN;
    logic [9:0]   limitMa;
    logic [22:0]  voltUv;
    logic         voltRsvd;
  } bbcca_regs_s;

endpackage

// [src/bbcca_volt_decode.sv]
// Target voltage code to microvolt decoder for both device variants
`timescale 1ns/10ps
`default_nettype none

module bbcca_volt_decode #(
  parameter bit HIGH_VOLT_VARIANT = 1'b0
) (
  input  wire logic [5:0]  code,
  output logic      [22:0] voltUv,
  output logic             reserved
);

  logic [5:0] stepIdx;

  always_comb
  begin
    if (HIGH_VOLT_VARIANT)
    begin
      stepIdx  = {code[1:0], code[5:2]};
      voltUv   = bbcca_pkg::VHIGH_BASE_UV + 23'(stepIdx) * bbcca_pkg::VHIGH_STEP_UV;
      reserved = (stepIdx > bbcca_pkg::VHIGH_MAX_IDX);
    end
    else
    begin
      stepIdx  = code;
      voltUv   = bbcca_pkg::VLOW_BASE_UV + 23'(stepIdx) * bbcca_pkg::VLOW_STEP_UV;
      reserved = 1'b0;
    end
  end

endmodule

`default_nettype wire

// [tb/bbcca_i2c_host.sv]
// I2C host model that reaches the configuration register over its pins
`timescale 1ns/10ps
`default_nettype none

module bbcca_i2c_host (
  input  wire logic clk_sys,
  input  wire logic sdaBus,
  output var logic  sclDrv,
  output var logic  sdaDrv
);
  initial
  begin
    sclDrv = 1'b1;
    sdaDrv = 1'b1;
  end

  // Four cycles a phase, above the three-cycle minimum
  task automatic ph();
    repeat (4) @(posedge clk_sys);
  endtask

  // Data moves only while the clock is low
  task automatic bitX(input logic b, output logic r);
    ph();
    sdaDrv <= b;
    ph();
    sclDrv <= 1'b1;
    ph();
    r = sdaBus;
    sclDrv <= 1'b0;
  endtask

  task automatic start();
    ph();
    sdaDrv <= 1'b1;
    ph();
    sclDrv <= 1'b1;
    ph();
    sdaDrv <= 1'b0;
    ph();
    sclDrv <= 1'b0;
  endtask

  task automatic stop();
    ph();
    sdaDrv <= 1'b0;
    ph();
    sclDrv <= 1'b1;
    ph();
    sdaDrv <= 1'b1;
    ph();
  endtask

  task automatic xfer(input logic [7:0] d, input logic mAck,
                      output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--)
      bitX(d[i], q[i]);
    bitX(mAck, ack);
  endtask

  task automatic wrReg(input logic [6:0] a, input logic [7:0] p, d, output logic ok);
    logic [7:0] q;
    logic       a0, a1, a2;
    start();
    xfer({a, 1'b0}, 1'b1, q, a0);
    xfer(p, 1'b1, q, a1);
    xfer(d, 1'b1, q, a2);
    stop();
    ok = !(a0 | a1 | a2);
  endtask

  task automatic rdReg(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d);
    logic [7:0] q;
    logic       n;
    start();
    xfer({a, 1'b0}, 1'b1, q, n);
    xfer(p, 1'b1, q, n);
    start();
    xfer({a, 1'b1}, 1'b1, q, n);
    xfer(8'hFF, 1'b1, d, n);
    stop();
  endtask
endmodule
`default_nettype wire

// [tb/buck_boost_ch1_config_a_bench.sv]
// Testbench for both variants of the channel one configuration register
`timescale 1ns/10ps
`default_nettype none

module buck_boost_ch1_config_a_bench;
  localparam logic [31:0] VLO0  = 32'h000C_3500;
  localparam logic [31:0] VLOST = 32'h0000_30D4;
  localparam logic [31:0] VHI0  = 32'h0024_9F00;
  localparam logic [31:0] VHIST = 32'h0000_C350;

  logic        clk_sys;
  logic        rst;
  logic        ceSig;
  logic        sysEvt;
  logic [7:0]  otpDef;
  logic [7:0]  d;
  logic        ok;
  int          idx;
  int          nFail;
  int          numChecks;
  wire logic   sclDrv;
  wire logic   sdaDrv;
  wire logic   sdaBus;
  logic        sOut [2];
  logic        oeN  [2];
  logic [1:0]  lim  [2];
  logic [5:0]  code [2];
  logic [9:0]  ma   [2];
  logic [22:0] uv   [2];
  logic        rsv  [2];
  logic [5:0]  loC  [4] = '{6'h00, 6'h01, 6'h20, 6'h3F};
  logic [5:0]  hiC  [4] = '{6'h01, 6'h27, 6'h2B, 6'h3C};
  logic [9:0]  limT [4] = '{10'h3E8, 10'h362, 10'h2C3, 10'h1F4};

  // Open-drain wire: any enabled driver pulls low
  assign sdaBus = sdaDrv & (oeN[0] | sOut[0]) & (oeN[1] | sOut[1]);

  // Instance 0 low variant at fuse 0, instance 1 high variant at fuse 1
  for (genvar g = 0; g < 2; g++)
  begin : gInst
    bbcca_config_reg #(.HIGH_VOLT_VARIANT(1'(g))) dut (
      .clk_sys(clk_sys), .rst(rst), .ce(ceSig), .sclIn(sclDrv), .sdaIn(sdaBus),
      .sdaOut(sOut[g]), .sdaOeN(oeN[g]), .otpAddrSel(1'(g)), .otpDefault(otpDef),
      .systemResetEvent(sysEvt), .ch1PeakCurrentLimit(lim[g]),
      .ch1TargetVoltageCode(code[g]), .peakLimitMa(ma[g]), .targetVoltUv(uv[g]),
      .targetVoltReserved(rsv[g])
    );
  end

  bbcca_i2c_host host (
    .clk_sys(clk_sys), .sdaBus(sdaBus), .sclDrv(sclDrv), .sdaDrv(sdaDrv)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    numChecks++;
    if (seen !== exp)
    begin
      nFail++;
      $display("unexpected %s: expected %0h, seen %0h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", numChecks, nFail);
    if (nFail == 0 && numChecks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Whole run is near 6500 cycles
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    nFail++;
    end_sim();
  end

  initial
  begin
    rst = 1'b1;
    sysEvt = 1'b0;
    otpDef = 8'h00;
    ceSig = 1'b1;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk("maRst", 32'(ma[0]), 32'h0000_03E8); // decode of zero
    chk("uvLoRst", 32'(uv[0]), VLO0); // base voltage
    chk("uvHiRst", 32'(uv[1]), VHI0); // base voltage
    otpDef <= 8'hA7;
    sysEvt <= 1'b1;
    @(posedge clk_sys);
    sysEvt <= 1'b0;
    @(posedge clk_sys);
    chk("fuseLo", 32'({lim[0], code[0]}), 32'h0000_00A7); // fuse reload
    chk("fuseHi", 32'({lim[1], code[1]}), 32'h0000_00A7); // fuse reload
    host.rdReg(7'h40, 8'h2B, d);
    chk("rdFuse", 32'(d), 32'h0000_00A7); // read back
    $display("test fuse reload done");
    for (int i = 0; i < 4; i++)
    begin
      host.wrReg(7'h40, 8'h2B, {2'(i), loC[i]}, ok);
      chk("ackLo", 32'(ok), 32'h0000_0001); // own address
      chk("limCode", 32'(lim[0]), 32'(i)); // limit field
      chk("limMa", 32'(ma[0]), 32'(limT[i])); // limit decode
      chk("uvLo", 32'(uv[0]), VLO0 + VLOST * 32'(loC[i])); // linear code
      host.rdReg(7'h40, 8'h2B, d);
      chk("rdLo", 32'(d), 32'({2'(i), loC[i]})); // read back
      chk("hiKept", 32'(code[1]), 32'h0000_0027); // other address
    end
    $display("test low variant done");
    for (int i = 0; i < 4; i++)
    begin
      host.wrReg(7'h48, 8'h2B, {2'h0, hiC[i]}, ok);
      idx = int'(hiC[i][5:2]) + 16 * int'(hiC[i][1:0]);
      chk("uvHi", 32'(uv[1]), VHI0 + VHIST * 32'(idx)); // scrambled code
      chk("rsvHi", 32'(rsv[1]), 32'(idx > 57)); // reserved range
      chk("loKept", 32'(code[0]), 32'h0000_003F); // other address
    end
    $display("test high variant done");
    host.wrReg(7'h50, 8'h2B, 8'h11, ok);
    chk("ackFor", 32'(ok), 32'h0000_0000); // foreign address
    chk("forKept", 32'(code[0]), 32'h0000_003F); // foreign address
    $display("test foreign address done");
    host.wrReg(7'h40, 8'h2C, 8'h11, ok);
    chk("ackMiss", 32'(ok), 32'h0000_0001); // unmapped pointer acked
    chk("missKept", 32'(code[0]), 32'h0000_003F); // write dropped
    host.rdReg(7'h40, 8'h2C, d);
    chk("rdMiss", 32'(d), 32'h0000_0000); // unmapped reads zero
    $display("test unmapped pointer done");
    // Reload request while frozen must wait for the enable
    ceSig <= 1'b0;
    otpDef <= 8'h5A;
    sysEvt <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("frozen", 32'({lim[0], code[0]}), 32'h0000_00FF); // held while frozen
    ceSig <= 1'b1;
    @(posedge clk_sys);
    sysEvt <= 1'b0;
    @(posedge clk_sys);
    chk("fuseCe", 32'({lim[0], code[0]}), 32'h0000_005A); // reload when enabled
    chk("maCe", 32'(ma[0]), 32'h0000_0362); // limit decode
    ceSig <= 1'b0;
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    ceSig <= 1'b1;
    @(posedge clk_sys);
    chk("rstFrz", 32'({lim[0], code[0]}), 32'h0000_0000); // reset beats freeze
    chk("maFrz", 32'(ma[0]), 32'h0000_03E8); // decode of zero
    $display("test clock enable done");
    end_sim();
  end
endmodule
`default_nettype wire
